/* File: src/ppmpc_top.sv */
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Normal mode: input when valid, else battery
// - Force-battery feeds rail from battery above lockout
// - Force-battery below lockout reverts to normal
// - Adapter reconnect cancels force-battery
// - Force-battery stops charging
// - Floating-off disconnects; input undervoltage restores normal
// - Pulled-down-off grounds rail; input toggle restores
// - Ship mode pulldown after battery switch off
// - Reset pulldown after both switches off, until autowake
// - Pulldown-off engages after both open; persists
// - Decode three-bit rail regulation target
// - Limit flag tracks clamp; mask gates interrupt
// - Input overvoltage: switches, pulse, fault, power-good
// - Overvoltage clear restores operation
// - Rail overvoltage opens input until falling
// - Rail short retries ten times then off
// - Battery overcurrent hiccup, latch after repeats
// - Supplement-mode hiccup needs input toggle
// - Per-phase safety timer, precharge quarter length
// - New duration restarts running timer
// - Doubling halves timer rate outside CC/CV
// - Watchdog starts on first transaction, restarts
// - Decode watchdog selection codes
module ppmpc_top
  import ppmpc_pkg::*;
#(
  parameter longint unsigned SHORT_ON_P  = SHORT_ON_CYC,
  parameter longint unsigned OCP_REC_P   = OCP_REC_CYC,
  parameter longint unsigned OCP_WIN_P   = OCP_WIN_CYC,
  parameter longint unsigned WDOG_LONG_P = WDOG_LONG_CYC,
  parameter longint unsigned WDOG_SHORT_P = WDOG_SHORT_CYC,
  parameter longint unsigned FAST_TMR_P  = 64'd1_800_000_000_000,
  parameter longint unsigned AUTOWAKE_P  = 64'd125_000_000
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       vin_valid,
  input  wire logic       vin_above_uvlo,
  input  wire logic       vin_ovp,
  input  wire logic       bat_above_uvlo,
  input  wire logic       rail_ovp_rise,
  input  wire logic       rail_ovp_fall,
  input  wire logic       rail_short,
  input  wire logic       battery_overcurrent,
  input  wire logic       supplement_active,
  input  wire logic       clamp_active,
  input  wire logic       precharge_phase,
  input  wire logic       fastcharge_phase,
  input  wire logic       charge_done,
  input  wire logic       cc_cv_loop,
  input  wire logic       ship_req,
  input  wire logic       hardware_power_cycle_req,
  input  wire logic       host_txn,
  input  wire logic       wr_rail_source,
  input  wire logic [1:0] wr_rail_source_val,
  input  wire logic       wr_timer_sel,
  input  wire logic [1:0] wr_timer_sel_val,
  input  wire logic [2:0] rail_regulation_target,
  input  wire logic       input_limit_irq_mask,
  input  wire logic       timer_doubling_enable,
  input  wire logic       charge_enable,
  input  wire logic [1:0] watchdog_sel,
  output logic [1:0]      rail_source_select,
  output logic            input_switch_on,
  output logic            battery_switch_on,
  output logic            rail_pulldown,
  output logic            charge_allowed,
  output logic [5:0]      rail_target_dv,
  output logic            rail_track_mode,
  output logic            rail_pass_mode,
  output logic            input_limit_active_flag,
  output logic            input_overvoltage_fault,
  output logic            input_overvoltage_status,
  output logic            input_power_good_status,
  output logic            charge_timer_fault,
  output logic            param_reset,
  output logic            hardware_power_cycle,
  output logic            int_n
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int NS = 11;
  logic [NS-1:0] raw, s1_q, s2_q;
  assign raw = {vin_valid, vin_above_uvlo, vin_ovp, bat_above_uvlo, rail_ovp_rise,
                rail_ovp_fall, rail_short, battery_overcurrent, supplement_active,
                clamp_active, charge_done};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  logic vin_ok, vin_uv_ok, ovp, bat_ok, sovp_r, sovp_f, sshort, bocp, supp, clamp, cdone;
  assign {vin_ok, vin_uv_ok, ovp, bat_ok, sovp_r, sovp_f, sshort, bocp, supp, clamp, cdone} = s2_q;

  logic vin_ok_q, vin_uv_q, ovp_q, clamp_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      vin_ok_q <= 1'b0;
      vin_uv_q <= 1'b0;
      ovp_q    <= 1'b0;
      clamp_q  <= 1'b0;
    end else begin
      vin_ok_q <= vin_ok;
      vin_uv_q <= vin_uv_ok;
      ovp_q    <= ovp;
      clamp_q  <= clamp;
    end
  end
  logic vin_rise, vin_fall, ovp_rise, clamp_rise;
  assign vin_rise   = vin_uv_ok && !vin_uv_q;
  assign vin_fall   = !vin_uv_ok && vin_uv_q;
  assign ovp_rise   = ovp && !ovp_q;
  assign clamp_rise = clamp && !clamp_q;

  // ****************************************************************
  // Rail source selection
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n || param_reset) begin
      rail_source_select <= RAIL_NORMAL;
    end else if (wr_rail_source) begin
      if (wr_rail_source_val == RAIL_FORCE_BAT && !bat_ok)
        rail_source_select <= RAIL_NORMAL;
      else
        rail_source_select <= wr_rail_source_val;
    end else if (rail_source_select == RAIL_FORCE_BAT && (vin_rise || !bat_ok)) begin
      rail_source_select <= RAIL_NORMAL;
    end else if (rail_source_select == RAIL_OFF_FLOAT && vin_fall) begin
      rail_source_select <= RAIL_NORMAL;
    end else if (rail_source_select == RAIL_OFF_PD && (vin_fall || vin_rise)) begin
      rail_source_select <= RAIL_NORMAL;
    end
  end

  // ****************************************************************
  // Protection sequencing
  // ****************************************************************
  typedef enum logic [1:0] {PPMPC_SS_IDLE, PPMPC_SS_ON, PPMPC_SS_OFF, PPMPC_SS_DEAD} ppmpc_ss_t;
  ppmpc_ss_t ss_q;
  logic [3:0] ss_tries_q;
  logic [40:0] ss_cnt_q;

  // Short-retry sequencer; a new adapter connection rearms it
  always_ff @(posedge clk) begin
    if (!rst_n || vin_rise) begin
      ss_q       <= PPMPC_SS_IDLE;
      ss_tries_q <= 4'h0;
      ss_cnt_q   <= '0;
    end else begin
      case (ss_q)
        PPMPC_SS_IDLE: if (sshort && vin_ok) begin
          ss_q     <= PPMPC_SS_OFF;
          ss_cnt_q <= 41'(SHORT_OFF_CYC);
        end
        PPMPC_SS_OFF: if (ss_cnt_q == '0) begin
          ss_q     <= PPMPC_SS_ON;
          ss_cnt_q <= 41'(SHORT_ON_P);
        end else begin
          ss_cnt_q <= ss_cnt_q - 41'h1;
        end
        PPMPC_SS_ON: if (!sshort) begin
          ss_q       <= PPMPC_SS_IDLE;
          ss_tries_q <= 4'h0;
        end else if (ss_cnt_q == '0) begin
          if (ss_tries_q == 4'(SHORT_MAX_TRIES - 1)) begin
            ss_q <= PPMPC_SS_DEAD;
          end else begin
            ss_tries_q <= ss_tries_q + 4'h1;
            ss_q       <= PPMPC_SS_OFF;
            ss_cnt_q   <= 41'(SHORT_OFF_CYC);
          end
        end else begin
          ss_cnt_q <= ss_cnt_q - 41'h1;
        end
        PPMPC_SS_DEAD: ss_q <= PPMPC_SS_DEAD;
        default: ss_q <= PPMPC_SS_IDLE;
      endcase
    end
  end

  // Battery overcurrent hiccup
  logic bsw_off_q, blatch_q, bsupp_latch_q;
  logic [2:0] ocp_hits_q;
  logic [40:0] rec_q, win_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bsw_off_q     <= 1'b0;
      blatch_q      <= 1'b0;
      bsupp_latch_q <= 1'b0;
      ocp_hits_q    <= 3'h0;
      rec_q         <= '0;
      win_q         <= '0;
    end else begin
      if (win_q != '0)
        win_q <= win_q - 41'h1;
      else
        ocp_hits_q <= 3'h0;
      if (vin_rise) begin
        blatch_q      <= 1'b0;
        bsupp_latch_q <= 1'b0;
        ocp_hits_q    <= 3'h0;
      end
      if (bocp && !bsw_off_q && !blatch_q && !bsupp_latch_q) begin
        bsw_off_q  <= 1'b1;
        rec_q      <= 41'(OCP_REC_P);
        ocp_hits_q <= ocp_hits_q + 3'h1;
        if (ocp_hits_q == 3'h0)
          win_q <= 41'(OCP_WIN_P);
        if (supp && vin_ok)
          bsupp_latch_q <= 1'b1;
        if (ocp_hits_q == 3'(OCP_MAX_TRIES - 1))
          blatch_q <= 1'b1;
      end else if (bsw_off_q && !blatch_q && !bsupp_latch_q) begin
        if (rec_q == '0)
          bsw_off_q <= 1'b0;
        else
          rec_q <= rec_q - 41'h1;
      end else if (!blatch_q && !bsupp_latch_q) begin
        bsw_off_q <= 1'b0;
      end
    end
  end

  // Rail overvoltage with hysteresis, rise at 105 % / fall at 102.5 %
  logic sovp_q;
  always_ff @(posedge clk) begin
    if (!rst_n)
      sovp_q <= 1'b0;
    else if (sovp_r)
      sovp_q <= 1'b1;
    else if (!sovp_f)
      sovp_q <= 1'b0;
  end

  // Input overvoltage fault flag: set wins over clear
  always_ff @(posedge clk) begin
    if (!rst_n)
      input_overvoltage_fault <= 1'b0;
    else if (ovp_rise)
      input_overvoltage_fault <= 1'b1;
    else if (host_txn)
      input_overvoltage_fault <= 1'b0;
  end

  // ****************************************************************
  // Power-cycle and pulldown sequencing
  // ****************************************************************
  logic aw_load, aw_done, aw_run;
  logic hw_wd;
  logic ship_q;
  assign aw_load = (hardware_power_cycle_req || hw_wd) && !aw_run;

  ppmpc_timer #(.W(41)) u_autowake (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (aw_load),
    .load_val (41'(AUTOWAKE_P)),
    .tick     (1'b1),
    .stop     (1'b0),
    .running  (aw_run),
    .done     (aw_done)
  );

  always_ff @(posedge clk) begin
    if (!rst_n)
      ship_q <= 1'b0;
    else if (vin_rise)
      ship_q <= 1'b0;
    else if (ship_req)
      ship_q <= 1'b1;
  end

  logic in_sw_d, bat_sw_d, pd_d;
  always_comb begin
    pd_d     = 1'b0;
    in_sw_d  = vin_ok && !ovp && !sovp_q
               && ss_q != PPMPC_SS_OFF && ss_q != PPMPC_SS_DEAD;
    bat_sw_d = bat_ok && !bsw_off_q;
    if (rail_source_select == RAIL_FORCE_BAT)
      in_sw_d = 1'b0;
    if (rail_source_select == RAIL_OFF_FLOAT || rail_source_select == RAIL_OFF_PD) begin
      in_sw_d  = 1'b0;
      bat_sw_d = 1'b0;
    end
    if (aw_run || ship_q) begin
      in_sw_d  = aw_run ? 1'b0 : in_sw_d;
      bat_sw_d = 1'b0;
    end
    if (in_sw_d)
      bat_sw_d = bat_sw_d && supp;
    if (ship_q && !battery_switch_on)
      pd_d = 1'b1;
    if ((aw_run || rail_source_select == RAIL_OFF_PD)
        && !battery_switch_on && !input_switch_on)
      pd_d = 1'b1;
  end

  // The battery switch (both switches outside ship mode) opens one cycle before the pulldown is allowed to engage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      input_switch_on   <= 1'b0;
      battery_switch_on <= 1'b0;
      rail_pulldown     <= 1'b0;
    end else begin
      input_switch_on   <= in_sw_d;
      battery_switch_on <= bat_sw_d;
      rail_pulldown     <= pd_d;
    end
  end

  // ****************************************************************
  // Regulation target decode
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rail_target_dv  <= TGT_BASE + 6'(REG_RESET);
      rail_track_mode <= 1'b0;
      rail_pass_mode  <= 1'b0;
    end else begin
      rail_track_mode <= rail_regulation_target == REG_TRACK;
      rail_pass_mode  <= rail_regulation_target == REG_PASS;
      rail_target_dv  <= (rail_regulation_target == REG_TRACK) ? TGT_FLOOR
                         : TGT_BASE + 6'(rail_regulation_target);
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      input_limit_active_flag  <= 1'b0;
      input_overvoltage_status <= 1'b0;
      input_power_good_status  <= 1'b0;
    end else begin
      input_limit_active_flag  <= clamp;
      input_overvoltage_status <= ovp;
      input_power_good_status  <= vin_ok && !ovp;
    end
  end

  // ****************************************************************
  // Safety timer
  // ****************************************************************
  logic [1:0] tsel_q;
  logic phase_pre_q, phase_fast_q, half_q, en_q, st_done, st_run;
  logic st_load;
  logic [42:0] st_len;

  always_ff @(posedge clk) begin
    if (!rst_n || param_reset)
      tsel_q <= TMR_SEL_RESET;
    else if (wr_timer_sel)
      tsel_q <= wr_timer_sel_val;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_pre_q  <= 1'b0;
      phase_fast_q <= 1'b0;
      half_q       <= 1'b0;
      en_q         <= 1'b0;
    end else begin
      phase_pre_q  <= precharge_phase;
      phase_fast_q <= fastcharge_phase;
      half_q       <= ~half_q;
      en_q         <= charge_enable;
    end
  end

  // Duration scales with the 2-bit selection; precharge is a quarter
  assign st_len = (43'(FAST_TMR_P) << tsel_q) >> ((precharge_phase) ? 2 : 0);
  assign st_load = (precharge_phase && !phase_pre_q) || (fastcharge_phase && !phase_fast_q)
                   || (wr_timer_sel && st_run);

  ppmpc_timer #(.W(43)) u_safety (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (st_load),
    .load_val (st_len),
    .tick     (!(timer_doubling_enable && !cc_cv_loop) || half_q),
    .stop     (cdone || !charge_allowed),
    .running  (st_run),
    .done     (st_done)
  );

  // A charge-enable toggle or input toggle is the only way out
  always_ff @(posedge clk) begin
    if (!rst_n)
      charge_timer_fault <= 1'b0;
    else if (st_done)
      charge_timer_fault <= 1'b1;
    else if ((en_q && !charge_enable) || vin_fall)
      charge_timer_fault <= 1'b0;
  end

  assign charge_allowed = charge_enable && !charge_timer_fault && input_switch_on
                          && rail_source_select == RAIL_NORMAL;

  // ****************************************************************
  // Host watchdog
  // ****************************************************************
  logic wd_seen_q, wd_done;
  always_ff @(posedge clk) begin
    if (!rst_n || param_reset)
      wd_seen_q <= 1'b0;
    else if (host_txn)
      wd_seen_q <= 1'b1;
  end

  ppmpc_timer #(.W(41)) u_wdog (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (host_txn && watchdog_sel != WD_OFF),
    .load_val ((watchdog_sel == WD_HW_40) ? 41'(WDOG_SHORT_P) : 41'(WDOG_LONG_P)),
    .tick     (wd_seen_q),
    .stop     (watchdog_sel == WD_OFF),
    .running  (),
    .done     (wd_done)
  );

  assign hw_wd = wd_done && watchdog_sel != WD_SW_160;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      param_reset          <= 1'b0;
      hardware_power_cycle <= 1'b0;
    end else begin
      param_reset          <= wd_done || aw_done;
      hardware_power_cycle <= aw_run;
    end
  end

  // ****************************************************************
  // Interrupt pulse
  // ****************************************************************
  ppmpc_pulse u_irq (
    .clk   (clk),
    .rst_n (rst_n),
    .trig  (ovp_rise || st_done || (clamp_rise && !input_limit_irq_mask)),
    .irq_n (int_n)
  );

endmodule
`default_nettype wire

/* File: inc/ppmpc_pkg.sv */
package ppmpc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned IRQ_PULSE_NS   = 128_000;
  localparam int unsigned IRQ_PULSE_CYC  = (IRQ_PULSE_NS * 125) / 1000;
  localparam int unsigned SHORT_ON_MS    = 5;
  localparam int unsigned SHORT_OFF_US   = 200;
  localparam int unsigned OCP_REC_MS     = 250;
  localparam int unsigned OCP_WIN_MS     = 2000;
  localparam longint unsigned SHORT_ON_CYC  = longint'(SHORT_ON_MS) * CLK_HZ / 1000;
  localparam longint unsigned SHORT_OFF_CYC = longint'(SHORT_OFF_US) * CLK_HZ / 1000000;
  localparam longint unsigned OCP_REC_CYC   = longint'(OCP_REC_MS) * CLK_HZ / 1000;
  localparam longint unsigned OCP_WIN_CYC   = longint'(OCP_WIN_MS) * CLK_HZ / 1000;
  localparam int unsigned WDOG_LONG_S    = 160;
  localparam int unsigned WDOG_SHORT_S   = 40;
  localparam longint unsigned WDOG_LONG_CYC  = longint'(WDOG_LONG_S) * CLK_HZ;
  localparam longint unsigned WDOG_SHORT_CYC = longint'(WDOG_SHORT_S) * CLK_HZ;
  localparam int unsigned SHORT_MAX_TRIES = 10;
  localparam int unsigned OCP_MAX_TRIES   = 4;
  localparam int unsigned PRECHG_DIV      = 4;

  // ****************************************************************
  // Encodings and reset values
  // ****************************************************************
  localparam logic [1:0] RAIL_NORMAL    = 2'h0;
  localparam logic [1:0] RAIL_FORCE_BAT = 2'h1;
  localparam logic [1:0] RAIL_OFF_FLOAT = 2'h2;
  localparam logic [1:0] RAIL_OFF_PD    = 2'h3;
  localparam logic [2:0] REG_TRACK      = 3'h0;
  localparam logic [2:0] REG_PASS       = 3'h7;
  localparam logic [2:0] REG_RESET      = 3'h2;
  localparam logic [1:0] WD_SW_160      = 2'h0;
  localparam logic [1:0] WD_HW_160      = 2'h1;
  localparam logic [1:0] WD_HW_40       = 2'h2;
  localparam logic [1:0] WD_OFF         = 2'h3;
  localparam logic [1:0] WD_RESET       = 2'h0;
  localparam logic [1:0] TMR_SEL_RESET  = 2'h1;
  localparam int unsigned TGT_W         = 6;
  // Target in 0.1 V units; tracking floor 3.8 V, offset 225 mV given in mV
  localparam logic [TGT_W-1:0] TGT_BASE = 6'h2B;
  localparam logic [TGT_W-1:0] TGT_FLOOR = 6'h26;
  localparam int unsigned TRACK_OFS_MV  = 225;

endpackage

/* File: src/ppmpc_timer.sv */
`timescale 1ns/10ps
`default_nettype none
// Loadable down counter: load wins, tick decrements, done pulses at zero
module ppmpc_timer
  import ppmpc_pkg::*;
#(
  parameter int W = 40
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         tick,
  input  wire logic         stop,
  output logic              running,
  output logic              done
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q   <= '0;
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        cnt_q   <= load_val;
        running <= 1'b1;
      end else if (stop) begin
        running <= 1'b0;
      end else if (running && tick) begin
        if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
          running <= 1'b0;
          done    <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: src/ppmpc_pulse.sv */
`timescale 1ns/10ps
`default_nettype none
// Stretches a trigger into a fixed-length active-low pulse
module ppmpc_pulse
  import ppmpc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic trig,
  output logic      irq_n
);
  logic [15:0] cnt_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      irq_n <= 1'b1;
    end else if (trig && cnt_q == 16'h0000) begin
      cnt_q <= 16'(IRQ_PULSE_CYC - 1);
      irq_n <= 1'b0;
    end else if (cnt_q != 16'h0000) begin
      cnt_q <= cnt_q - 16'h0001;
    end else begin
      irq_n <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: sim/ppmpc_props.sv */
`timescale 1ns/10ps
`default_nettype none
module ppmpc_props
  import ppmpc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       vin_ovp,
  input wire logic       clamp_active,
  input wire logic [2:0] rail_regulation_target,
  input wire logic [1:0] rail_source_select,
  input wire logic       input_switch_on,
  input wire logic       battery_switch_on,
  input wire logic       rail_pulldown,
  input wire logic       charge_allowed,
  input wire logic [5:0] rail_target_dv,
  input wire logic       input_limit_active_flag,
  input wire logic       input_overvoltage_fault,
  input wire logic       input_power_good_status,
  input wire logic       int_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] low_q;
  always_ff @(posedge clk) low_q <= (!rst_n || int_n) ? 16'h0 : low_q + 16'h1;
  sequence s_ovp_hit;
    !int_n && input_overvoltage_fault && !input_power_good_status;
  endsequence
  a_fb_input_off: assert property (
    rail_source_select == RAIL_FORCE_BAT |=> !input_switch_on) else $error("input on");
  a_fb_no_charge: assert property (
    (rail_source_select == RAIL_FORCE_BAT) [*2] |-> !charge_allowed) else $error("charging");
  a_pd_mode_on: assert property (
    (rail_source_select == RAIL_OFF_PD) [*3] |-> rail_pulldown) else $error("no pulldown");
  a_pd_after_open: assert property (
    rail_pulldown |-> !input_switch_on && !battery_switch_on) else $error("pulldown early");
  a_reg_fixed: assert property (
    rail_regulation_target inside {[3'h1:3'h6]}
    |=> rail_target_dv == TGT_BASE + 6'($past(rail_regulation_target))) else $error("target");
  a_clamp_flag: assert property (
    $rose(clamp_active) |-> ##[2:3] input_limit_active_flag) else $error("limit flag");
  a_ovp_react: assert property (
    $rose(vin_ovp) |-> ##[1:4] s_ovp_hit) else $error("overvoltage reaction");
  a_irq_width: assert property (
    $rose(int_n) |-> low_q == 16'(IRQ_PULSE_CYC)) else $error("pulse width");
endmodule
bind ppmpc_top ppmpc_props u_props (.*);
`default_nettype wire

/* File: sim/ppmpc_host.sv */
`timescale 1ns/10ps
`default_nettype none
module ppmpc_host (
  input  wire logic clk,
  output logic      host_txn,
  output logic      wr_rail_source,
  output logic [1:0] wr_rail_source_val,
  output logic      charge_enable
);
  initial begin
    host_txn = 1'b0;
    wr_rail_source = 1'b0;
    wr_rail_source_val = 2'h0;
    charge_enable = 1'b0;
  end
  task automatic wr_mode(input logic [1:0] v);
    @(negedge clk);
    host_txn = 1'b1;
    wr_rail_source = 1'b1;
    wr_rail_source_val = v;
    @(negedge clk);
    host_txn = 1'b0;
    wr_rail_source = 1'b0;
    wr_rail_source_val = ~v; // Released data must not hold the last value
  endtask
  task automatic chg_toggle();
    @(negedge clk);
    charge_enable = 1'b0;
    @(negedge clk);
    charge_enable = 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench
  import ppmpc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic vin_valid, vin_above_uvlo, vin_ovp, bat_above_uvlo, rail_ovp_rise, rail_ovp_fall;
  logic rail_short, battery_overcurrent, supplement_active, clamp_active, precharge_phase;
  logic fastcharge_phase, charge_done, cc_cv_loop, ship_req, hardware_power_cycle_req, wr_timer_sel;
  logic input_limit_irq_mask, timer_doubling_enable, host_txn, wr_rail_source, charge_enable;
  logic [1:0] wr_rail_source_val, wr_timer_sel_val, watchdog_sel, rail_source_select;
  logic [2:0] rail_regulation_target;
  logic [5:0] rail_target_dv;
  logic input_switch_on, battery_switch_on, rail_pulldown, charge_allowed, rail_track_mode;
  logic rail_pass_mode, input_limit_active_flag, input_overvoltage_fault, param_reset;
  logic input_overvoltage_status, input_power_good_status, charge_timer_fault, int_n;
  logic hardware_power_cycle;
  int mismatches = 0;
  int checked = 0;
  int n;
  ppmpc_top #(.WDOG_LONG_P(400), .WDOG_SHORT_P(200), .AUTOWAKE_P(50), .FAST_TMR_P(100)) DUT (.*);
  ppmpc_host hst (.*);
  always #4 clk = ~clk;
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic vin(input logic v);
    vin_valid = v;
    vin_above_uvlo = v;
    cyc(5);
  endtask
  initial begin
    #400_000;
    mismatches++;
    close_out();
  end
  initial begin
    {vin_valid, vin_above_uvlo, vin_ovp, bat_above_uvlo, rail_ovp_rise, rail_ovp_fall, rail_short,
     battery_overcurrent, supplement_active, clamp_active, precharge_phase, fastcharge_phase,
     charge_done, cc_cv_loop, ship_req, hardware_power_cycle_req, wr_timer_sel, wr_timer_sel_val,
     input_limit_irq_mask, timer_doubling_enable} = '0;
    rail_regulation_target = REG_RESET;
    watchdog_sel = WD_OFF;
    cyc(3);
    rst_n = 1'b1;
    chk(rail_target_dv, TGT_BASE + 6'h2);
    hst.chg_toggle();
    vin(1'b1);
    chk({rail_source_select, input_switch_on}, 8'h1);
    hst.wr_mode(RAIL_FORCE_BAT);
    chk(rail_source_select, RAIL_NORMAL);
    bat_above_uvlo = 1'b1;
    cyc(5);
    hst.wr_mode(RAIL_FORCE_BAT);
    cyc(3);
    chk({rail_source_select, input_switch_on, battery_switch_on, charge_allowed}, 8'h0A);
    vin(1'b0);
    chk({input_switch_on, battery_switch_on}, 8'h1);
    vin(1'b1);
    chk(rail_source_select, RAIL_NORMAL);
    hst.wr_mode(RAIL_OFF_FLOAT);
    cyc(3);
    chk({rail_source_select, input_switch_on, rail_pulldown}, 8'h8);
    vin(1'b0);
    vin(1'b1);
    chk(rail_source_select, RAIL_NORMAL);
    hst.wr_mode(RAIL_OFF_PD);
    cyc(4);
    chk({rail_pulldown, battery_switch_on}, 8'h2);
    hst.wr_mode(RAIL_NORMAL);
    cyc(4);
    chk(rail_pulldown, 1'b0);
    for (int c = 1; c < 7; c++) begin
      rail_regulation_target = 3'(c);
      cyc(2);
      chk(rail_target_dv, TGT_BASE + 6'(c));
    end
    rail_regulation_target = REG_PASS;
    cyc(2);
    chk(rail_pass_mode, 1'b1);
    rail_regulation_target = REG_TRACK;
    cyc(2);
    chk(rail_track_mode, 1'b1);
    clamp_active = 1'b1;
    input_limit_irq_mask = 1'b1;
    cyc(4);
    chk({input_limit_active_flag, int_n}, 8'h3);
    clamp_active = 1'b0;
    vin_ovp = 1'b1;
    cyc(4);
    chk({input_overvoltage_fault, int_n, input_power_good_status}, 8'h4);
    chk({input_overvoltage_status, input_switch_on, battery_switch_on}, 8'h5);
    vin_ovp = 1'b0;
    cyc(5);
    chk({input_overvoltage_status, input_power_good_status, input_switch_on}, 8'h3);
    n = 0;
    while (int_n !== 1'b1 && n < 17000) begin
      cyc(1);
      n++;
    end
    chk(8'(n / 1000), 8'h0F);
    watchdog_sel = WD_HW_40;
    hst.wr_mode(RAIL_NORMAL);
    n = 0;
    while (param_reset !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    chk(8'(n / 10), 8'h14);
    cyc(1);
    chk(hardware_power_cycle, 1'b1);
    cyc(2);
    chk({rail_pulldown, input_switch_on, battery_switch_on}, 8'h4);
    watchdog_sel = WD_OFF;
    cyc(80);
    chk({hardware_power_cycle, rail_pulldown, input_switch_on}, 8'h1);
    fastcharge_phase = 1'b1;
    cyc(195);
    chk({charge_timer_fault, int_n}, 8'h1);
    cyc(10);
    chk({charge_timer_fault, int_n, charge_allowed}, 8'h4);
    hst.chg_toggle();
    chk(charge_timer_fault, 1'b0);
    cyc(10);
    close_out();
  end
endmodule
`default_nettype wire
